// ---- design/wscu_pkg.sv ----
// Package of operation codes, field widths and timing for the shift/compare unit.
package wscu_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned WSCU_XLEN      = 64;
  localparam int unsigned WSCU_WLEN      = 32;
  localparam int unsigned WSCU_SHAMT_W   = 5;
  localparam int unsigned WSCU_IMM_W     = 16;
  localparam int unsigned WSCU_REGIDX_W  = 5;
  localparam int unsigned WSCU_SIGN_BIT  = 31;

  // ----------------------------------------------------------------------
  // Special forms and timing
  // ----------------------------------------------------------------------
  localparam logic [4:0] WSCU_ZERO_REG     = 5'h00;
  localparam logic [4:0] WSCU_NOP_SHAMT    = 5'h00;
  localparam logic [4:0] WSCU_SSNOP_SHAMT  = 5'h01;
  localparam int unsigned WSCU_LATENCY     = 1;
  localparam logic [63:0] WSCU_RESULT_RST  = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    WSCU_OP_SHIFT_LEFT_FIXED            = 4'h0,
    WSCU_OP_SHIFT_LEFT_VARIABLE         = 4'h1,
    WSCU_OP_SHIFT_RIGHT_LOGICAL_FIXED   = 4'h2,
    WSCU_OP_SHIFT_RIGHT_ARITH_FIXED     = 4'h3,
    WSCU_OP_SHIFT_RIGHT_ARITH_VARIABLE  = 4'h4,
    WSCU_OP_LESS_THAN_SIGNED_REG        = 4'h5,
    WSCU_OP_LESS_THAN_UNSIGNED_REG      = 4'h6,
    WSCU_OP_LESS_THAN_SIGNED_IMM        = 4'h7,
    WSCU_OP_LESS_THAN_UNSIGNED_IMM      = 4'h8
  } wscu_op_t;

endpackage : wscu_pkg

// ---- design/wscu_shifter.sv ----
// Combinational 32-bit word shifter with sign-extended 64-bit result.
module wscu_shifter
  import wscu_pkg::*;
(
  // Operand and control
  input  wire logic [63:0] word_src,
  input  wire logic [4:0]  amount,
  input  wire logic        dir_right,
  input  wire logic        arith,
  // Result
  output wire logic [63:0] result
);

  // Only the low word is used, so a badly extended source still
  // yields a proper sign-extended result for left shifts.
  wire logic [31:0] low_word;
  wire logic        fill_bit;
  wire logic [63:0] right_ext;
  wire logic [31:0] left_word;
  wire logic [31:0] right_word;
  wire logic [31:0] shifted;

  assign low_word   = word_src[31:0];
  assign fill_bit   = arith & low_word[WSCU_SIGN_BIT];
  assign right_ext  = {{32{fill_bit}}, low_word};
  assign left_word  = low_word << amount;
  assign right_word = 32'(right_ext >> amount);
  assign shifted    = dir_right ? right_word : left_word;
  assign result     = {{32{shifted[31]}}, shifted};

endmodule // wscu_shifter

// ---- design/wscu_unit.sv ----
// Word shift and set-on-less-than execution unit with registered result.
//
// Functional notes
// RULE1 - Fixed left shift: low word shifted by field, zero fill, sign-extended.
// RULE2 - Left shifts accept any 64-bit source; count zero sign-extends low word.
// RULE3 - Zero-register fixed left shift with count 0 or 1 acts as no-op.
// RULE4 - Variable left shift: low word shifted by register amount, sign-extended.
// RULE5 - Variable shifts use only the low 5 bits of the count register.
// RULE6 - Signed register compare writes 1 if first less, else 0.
// RULE7 - No compare ever raises an integer overflow exception.
// RULE8 - Signed immediate compare sign-extends 16-bit immediate, compares signed.
// RULE9 - Unsigned immediate compare sign-extends immediate, then compares unsigned.
// RULE10 - Unsigned register compare writes 1 if first smaller, else 0.
// RULE11 - Arithmetic right shifts replicate bit 31; result sign-extended.
// RULE12 - Fixed logical right shift zero-fills low word; result sign-extended.
// RULE13 - Software supplies sign-extended words for right shifts.
module wscu_unit
  import wscu_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     clk_en,
  // Request from decode stage
  input  wire logic                     issue_valid,
  input  wire wscu_pkg::wscu_op_t       op,
  input  wire logic [63:0]              first_source_reg,
  input  wire logic [63:0]              second_source_reg,
  input  wire logic [4:0]               shift_amount_field,
  input  wire logic [15:0]              immediate,
  input  wire logic [4:0]               dest_index,
  // Result to general register file
  output logic                          result_valid,
  output logic [63:0]                   result_data,
  output logic [4:0]                    result_index,
  output logic                          result_write,
  output logic                          issue_break,
  output logic                          overflow_exc
);

  // ----------------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------------
  wire logic is_shift;
  wire logic is_fixed;
  wire logic is_right;
  wire logic is_arith;
  wire logic is_nop_form;
  wire logic [4:0] shift_count;
  wire logic [63:0] shift_result;

  assign is_shift = (op == WSCU_OP_SHIFT_LEFT_FIXED)
                  | (op == WSCU_OP_SHIFT_LEFT_VARIABLE)
                  | (op == WSCU_OP_SHIFT_RIGHT_LOGICAL_FIXED)
                  | (op == WSCU_OP_SHIFT_RIGHT_ARITH_FIXED)
                  | (op == WSCU_OP_SHIFT_RIGHT_ARITH_VARIABLE);
  assign is_fixed = (op == WSCU_OP_SHIFT_LEFT_FIXED)
                  | (op == WSCU_OP_SHIFT_RIGHT_LOGICAL_FIXED)
                  | (op == WSCU_OP_SHIFT_RIGHT_ARITH_FIXED);
  assign is_right = (op == WSCU_OP_SHIFT_RIGHT_LOGICAL_FIXED)
                  | (op == WSCU_OP_SHIFT_RIGHT_ARITH_FIXED)
                  | (op == WSCU_OP_SHIFT_RIGHT_ARITH_VARIABLE);
  assign is_arith = (op == WSCU_OP_SHIFT_RIGHT_ARITH_FIXED)
                  | (op == WSCU_OP_SHIFT_RIGHT_ARITH_VARIABLE); // RULE11

  // Variable forms take the count register's low bits; the rest is ignored.
  assign shift_count = is_fixed ? shift_amount_field
                                : second_source_reg[WSCU_SHAMT_W-1:0]; // RULE5

  // The value operand of every shift is the first source.
  wscu_shifter u_shifter (
    .word_src  (first_source_reg),
    .amount    (shift_count),
    .dir_right (is_right),
    .arith     (is_arith),
    .result    (shift_result)
  ); // RULE1 RULE2 RULE4 RULE12

  // ----------------------------------------------------------------------
  // Comparisons
  // ----------------------------------------------------------------------
  // Comparators, not subtract-and-trap, so no overflow can arise.
  wire logic [63:0] imm_ext;
  wire logic        lt_signed_reg;
  wire logic        lt_unsigned_reg;
  wire logic        lt_signed_imm;
  wire logic        lt_unsigned_imm;
  wire logic        cmp_bit;
  wire logic [63:0] cmp_result;

  assign imm_ext = {{48{immediate[WSCU_IMM_W-1]}}, immediate}; // RULE8 RULE9
  assign lt_signed_reg   = $signed(first_source_reg)
                         < $signed(second_source_reg); // RULE6
  assign lt_unsigned_reg = first_source_reg < second_source_reg; // RULE10
  assign lt_signed_imm   = $signed(first_source_reg) < $signed(imm_ext); // RULE8
  assign lt_unsigned_imm = first_source_reg < imm_ext; // RULE9
  assign cmp_bit = (op == WSCU_OP_LESS_THAN_SIGNED_REG)   ? lt_signed_reg
                 : (op == WSCU_OP_LESS_THAN_UNSIGNED_REG) ? lt_unsigned_reg
                 : (op == WSCU_OP_LESS_THAN_SIGNED_IMM)   ? lt_signed_imm
                 : lt_unsigned_imm;
  assign cmp_result = {63'h0, cmp_bit}; // RULE6 RULE10

  // ----------------------------------------------------------------------
  // No-operation forms
  // ----------------------------------------------------------------------
  // Writes to register zero are suppressed anyway; the count-1 form
  // additionally asks the issue logic to break the issue group.
  assign is_nop_form = (op == WSCU_OP_SHIFT_LEFT_FIXED)
                     & (dest_index == WSCU_ZERO_REG); // RULE3

  wire logic        do_write;
  wire logic        do_break;
  wire logic [63:0] result_next;
  wire logic        known_op;

  assign known_op = is_shift | (op == WSCU_OP_LESS_THAN_SIGNED_REG)
                  | (op == WSCU_OP_LESS_THAN_UNSIGNED_REG)
                  | (op == WSCU_OP_LESS_THAN_SIGNED_IMM)
                  | (op == WSCU_OP_LESS_THAN_UNSIGNED_IMM);
  assign do_write = issue_valid & known_op
                  & (dest_index != WSCU_ZERO_REG); // RULE3
  assign do_break = issue_valid & is_nop_form
                  & (shift_amount_field == WSCU_SSNOP_SHAMT); // RULE3
  assign result_next = is_shift ? shift_result : cmp_result;

  // ----------------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_valid <= 1'b0;
      result_write <= 1'b0;
      issue_break  <= 1'b0;
      result_data  <= WSCU_RESULT_RST;
      result_index <= WSCU_ZERO_REG;
    end else if (clk_en) begin
      result_valid <= issue_valid;
      result_write <= do_write;
      issue_break  <= do_break;
      result_data  <= issue_valid ? result_next : result_data;
      result_index <= issue_valid ? dest_index : result_index;
    end
  end

  assign overflow_exc = 1'b0; // RULE7

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_rule1;
    @(posedge clk) disable iff (!nrst)
    (clk_en && issue_valid && op == WSCU_OP_SHIFT_LEFT_FIXED)
      |=> result_data[31:0] == 32'($past(first_source_reg[31:0])
                                    << $past(shift_amount_field));
  endproperty
  a_rule1: assert property (p_rule1) else $error("fixed left wrong"); // RULE1

  property p_rule2;
    @(posedge clk) disable iff (!nrst)
    (clk_en && issue_valid && is_shift && !is_right && shift_count == 5'h00)
      |=> result_data == {{32{$past(first_source_reg[31])}},
                          $past(first_source_reg[31:0])};
  endproperty
  a_rule2: assert property (p_rule2) else $error("zero shift trunc"); // RULE2

  property p_rule3;
    @(posedge clk) disable iff (!nrst)
    (clk_en && issue_valid && op == WSCU_OP_SHIFT_LEFT_FIXED
     && dest_index == 5'h00)
      |=> !result_write && issue_break == ($past(shift_amount_field) == 5'h01);
  endproperty
  a_rule3: assert property (p_rule3) else $error("nop form wrong"); // RULE3

  property p_rule4;
    @(posedge clk) disable iff (!nrst)
    (clk_en && issue_valid && op == WSCU_OP_SHIFT_LEFT_VARIABLE)
      |=> result_data[63:31] == {33{result_data[31]}};
  endproperty
  a_rule4: assert property (p_rule4) else $error("var left extend"); // RULE4

  property p_rule5;
    @(posedge clk) disable iff (!nrst)
    (clk_en && issue_valid && op == WSCU_OP_SHIFT_LEFT_VARIABLE)
      |=> result_data[31:0] == 32'($past(first_source_reg[31:0])
                                    << $past(second_source_reg[4:0]));
  endproperty
  a_rule5: assert property (p_rule5) else $error("var count"); // RULE5

  property p_rule6;
    @(posedge clk) disable iff (!nrst)
    (clk_en && issue_valid && op == WSCU_OP_LESS_THAN_SIGNED_REG)
      |=> result_data == {63'h0, $signed($past(first_source_reg))
                                 < $signed($past(second_source_reg))};
  endproperty
  a_rule6: assert property (p_rule6) else $error("signed cmp"); // RULE6

  property p_rule8;
    @(posedge clk) disable iff (!nrst)
    (clk_en && issue_valid && op == WSCU_OP_LESS_THAN_SIGNED_IMM)
      |=> result_data == {63'h0, $signed($past(first_source_reg))
                          < $signed({{48{$past(immediate[15])}},
                                     $past(immediate)})};
  endproperty
  a_rule8: assert property (p_rule8) else $error("signed imm"); // RULE8

  property p_rule10;
    @(posedge clk) disable iff (!nrst)
    (clk_en && issue_valid && op == WSCU_OP_LESS_THAN_UNSIGNED_REG)
      |=> result_data == {63'h0, $past(first_source_reg)
                                 < $past(second_source_reg)};
  endproperty
  a_rule10: assert property (p_rule10) else $error("unsigned cmp"); // RULE10

  property p_rule7;
    @(posedge clk) disable iff (!nrst) !overflow_exc;
  endproperty
  a_rule7: assert property (p_rule7) else $error("overflow raised"); // RULE7

  property p_rule9;
    @(posedge clk) disable iff (!nrst)
    (clk_en && issue_valid && op == WSCU_OP_LESS_THAN_UNSIGNED_IMM
     && first_source_reg == 64'h0 && immediate[15])
      |=> result_data == 64'h1;
  endproperty
  a_rule9: assert property (p_rule9) else $error("unsigned imm"); // RULE9

  property p_rule11;
    @(posedge clk) disable iff (!nrst)
    (clk_en && issue_valid && is_arith)
      |=> result_data[63:31] == {33{$past(first_source_reg[31])}};
  endproperty
  a_rule11: assert property (p_rule11) else $error("arith fill"); // RULE11

  property p_rule12;
    @(posedge clk) disable iff (!nrst)
    (clk_en && issue_valid && op == WSCU_OP_SHIFT_RIGHT_LOGICAL_FIXED
     && shift_amount_field != 5'h00)
      |=> result_data[63:31] == 33'h0;
  endproperty
  a_rule12: assert property (p_rule12) else $error("logical fill"); // RULE12

endmodule // wscu_unit

// ---- verif/wscu_regfile_model.sv ----
// Behavioural general register file that receives the unit's results.
module wscu_regfile_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Write side
  input  wire logic        result_write,
  input  wire logic [4:0]  result_index,
  input  wire logic [63:0] result_data,
  // Read side
  input  wire logic [4:0]  rd_index,
  output logic      [63:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] regs_reg [32];

  // Entry zero stays hard-wired to zero, so a stray write there is lost.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 32; i++) regs_reg[i] <= 64'h0;
    end else if (result_write && result_index != 5'h00) begin
      regs_reg[result_index] <= result_data;
    end
  end
  assign rd_data = regs_reg[rd_index];
endmodule // wscu_regfile_model

// ---- verif/wscu_unit_tb_top.sv ----
// Self-checking testbench for the word shift and compare unit.
module wscu_unit_tb_top import wscu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [63:0] d;
    logic [4:0]  i;
    logic        w;
    logic        b;
  } wscu_exp_t;
  logic clk = 0, nrst = 0, clk_en = 1, issue_valid = 0;
  wscu_op_t op = WSCU_OP_SHIFT_LEFT_FIXED;
  logic [63:0] src_a = 0, src_b = 0, r_data, rd_data;
  logic [4:0]  sa = 0, dest = 0, r_index, rd_index = 0;
  logic [15:0] imm = 0;
  logic        r_valid, r_write, r_break, r_ovf;
  wscu_exp_t   exp_q[$];
  wscu_exp_t   e;
  int          num_errors = 0, n_tests = 0;
  logic        en_seen_reg = 1'b0;
  logic [63:0] tab[4] = '{64'h0, 64'h1, '1, 64'h8000_0000_0000_0000};
  logic [15:0] itab[4] = '{16'h0, 16'h7FFF, 16'hFFFF, 16'h8000};

  always #25 clk = ~clk;

  wscu_unit u_wscu_unit (.clk(clk), .nrst(nrst), .clk_en(clk_en),
    .issue_valid(issue_valid), .op(op), .first_source_reg(src_a),
    .second_source_reg(src_b), .shift_amount_field(sa), .immediate(imm),
    .dest_index(dest), .result_valid(r_valid), .result_data(r_data),
    .result_index(r_index), .result_write(r_write), .issue_break(r_break),
    .overflow_exc(r_ovf));
  wscu_regfile_model u_wscu_regfile_model (.clk(clk), .nrst(nrst),
    .result_write(r_write), .result_index(r_index), .result_data(r_data),
    .rd_index(rd_index), .rd_data(rd_data));

  function automatic logic [63:0] sx(input logic [31:0] w);
    return {{32{w[31]}}, w};
  endfunction

  function automatic logic [63:0] model(input wscu_op_t o,
      input logic [63:0] a, b, input logic [4:0] s, input logic [15:0] im);
    logic [63:0] ie;
    ie = {{48{im[15]}}, im};
    case (o)
      WSCU_OP_SHIFT_LEFT_FIXED: return sx(a[31:0] << s);
      WSCU_OP_SHIFT_LEFT_VARIABLE: return sx(a[31:0] << b[4:0]);
      WSCU_OP_SHIFT_RIGHT_LOGICAL_FIXED: return sx(a[31:0] >> s);
      WSCU_OP_SHIFT_RIGHT_ARITH_FIXED:
        return sx($signed(a[31:0]) >>> s);
      WSCU_OP_SHIFT_RIGHT_ARITH_VARIABLE:
        return sx($signed(a[31:0]) >>> b[4:0]);
      WSCU_OP_LESS_THAN_SIGNED_REG:
        return {63'h0, $signed(a) < $signed(b)};
      WSCU_OP_LESS_THAN_UNSIGNED_REG: return {63'h0, a < b};
      WSCU_OP_LESS_THAN_SIGNED_IMM:
        return {63'h0, $signed(a) < $signed(ie)};
      default: return {63'h0, a < ie};
    endcase
  endfunction

  task automatic check(input string name, input logic [63:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Only an enabled request is noted, since a frozen edge takes nothing.
  task automatic issue(input wscu_op_t o, input logic [63:0] a, b,
      input logic [4:0] s, input logic [15:0] im, input logic [4:0] d);
    wscu_exp_t x;
    @(negedge clk);
    issue_valid = 1;
    op = o;
    src_a = a;
    src_b = b;
    sa = s;
    imm = im;
    dest = d;
    x = '{model(o, a, b, s, im), d, d != 5'h00,
          o == WSCU_OP_SHIFT_LEFT_FIXED && d == 5'h00 && s == 5'h01};
    if (clk_en) exp_q.push_back(x);
  endtask

  task automatic idle();
    @(negedge clk);
    issue_valid = 0;
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------------
  // A frozen edge holds the last valid pulse, so only enabled edges count.
  always @(posedge clk) en_seen_reg <= clk_en;

  always @(negedge clk) begin
    if (nrst && en_seen_reg && r_valid === 1'b1) begin
      check("overflow", r_ovf, 64'h0);
      if (exp_q.size() == 0) check("spurious", 64'h1, 64'h0);
      else begin
        e = exp_q.pop_front();
        check("data", r_data, e.d);
        check("index", r_index, e.i);
        check("write", r_write, e.w);
        check("break", r_break, e.b);
      end
    end
  end

  initial begin
    #150000;
    num_errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    logic [63:0] a;
    void'($urandom(32'h635D));
    repeat (10) @(posedge clk);
    check("reset data", r_data, WSCU_RESULT_RST);
    @(negedge clk) nrst = 1;
    for (int o = 0; o < 5; o++) begin
      for (int k = 0; k < 24; k++) begin
        a = {$urandom, $urandom};
        if (o > 1) a = sx(a[31:0]);
        issue(wscu_op_t'(o), a, {$urandom, $urandom}, 5'($urandom),
              16'h0, 5'($urandom_range(31, 1)));
      end
    end
    $display("Test shifts done");
    for (int o = 5; o < 9; o++) begin
      for (int i = 0; i < 16; i++) begin
        issue(wscu_op_t'(o), tab[i % 4], {{48{itab[i / 4][15]}}, itab[i / 4]},
              5'h00, itab[i / 4], 5'(i + 1));
      end
    end
    $display("Test compares done");
    issue(WSCU_OP_SHIFT_LEFT_FIXED, 64'h0, 64'h0, 5'h00, 16'h0, 5'h00);
    issue(WSCU_OP_SHIFT_LEFT_FIXED, 64'h0, 64'h0, 5'h01, 16'h0, 5'h00);
    issue(WSCU_OP_SHIFT_LEFT_FIXED, 64'h0123_4567_89AB_CDEF, 64'h0,
          5'h00, 16'h0, 5'h04);
    issue(WSCU_OP_LESS_THAN_SIGNED_REG, '1, 64'h0, 5'h00, 16'h0, 5'h00);
    $display("Test no-op forms done");
    idle();
    clk_en = 0;
    issue(WSCU_OP_SHIFT_LEFT_FIXED, 64'h1, 64'h0, 5'h04, 16'h0, 5'h03);
    idle();
    check("frozen valid", r_valid, 64'h1);
    check("frozen data", r_data, 64'h1);
    clk_en = 1;
    issue(WSCU_OP_SHIFT_LEFT_FIXED, 64'h1, 64'h0, 5'h04, 16'h0, 5'h03);
    idle();
    idle();
    rd_index = 5'h03;
    #1 check("regfile", rd_data, 64'h10);
    $display("Test enable and write-back done");
    repeat (3) idle();
    check("pending", 64'(exp_q.size()), 64'h0);
    report_and_stop();
  end
endmodule // wscu_unit_tb_top
